// *** src/spsi_top.v ***
// The plain strobed port was chosen for this implementation.
`include "spsi_defs.vh"

module spsi_top #(
    parameter DW = 8
) (
    input  wire                mclk,
    input  wire                rst,
    input  wire                ce,
    input  wire [`SPSI_AW-1:0] bus_addr,
    input  wire [31:0]         bus_wdata,
    input  wire                bus_wr,
    input  wire                bus_rd,
    output reg  [31:0]         bus_rdata,
    input  wire                tx_load,
    input  wire                tx_frame_done,
    input  wire                rx_frame_done,
    input  wire [DW-1:0]       rx_line_data,
    input  wire                idle_det,
    input  wire                noise_det,
    input  wire                frame_err_det,
    input  wire                parity_err_det,
    input  wire                lin_break_det,
    input  wire                rx_timeout_det,
    input  wire                block_end_det,
    input  wire                cts_n,
    output reg  [DW-1:0]       tx_line_data,
    output reg                 tx_line_parity,
    output reg                 tx_data_written,
    output wire                high_bit_first,
    output wire                data_level_invert,
    output wire                irq
);
    reg  [`SPSI_CTL_W-1:0] ctl0_r;
    reg  [`SPSI_CTL_W-1:0] ctl1_r;
    reg  [`SPSI_CTL_W-1:0] ctl2_r;
    reg  [`SPSI_CTL_W-1:0] ctl3_r;
    reg  [DW-1:0]          rx_buf_r;
    reg                    tx_buffer_empty;
    reg                    tx_complete;
    reg                    rx_not_empty;
    reg                    idle_line_flag;
    reg                    overrun_flag;
    reg                    noise_flag;
    reg                    framing_flag;
    reg                    parity_flag;
    reg                    lin_break_flag;
    reg                    flow_ctrl_change;
    reg                    rx_timeout_flag;
    reg                    block_end_flag;
    reg                    cts_prev_r;
    reg                    cts_seen_r;

    wire [DW-1:0] tx_mapped;
    wire [DW-1:0] rx_mapped;
    wire [`SPSI_SEQ_N-1:0] seq_flags;
    wire [`SPSI_SEQ_N-1:0] seq_clr_rd;
    wire [`SPSI_SEQ_N-1:0] seq_clr_wr;
    wire [31:0] stat_word;
    wire [31:0] stat1_word;

    wire stat_rd = bus_rd && (bus_addr == `SPSI_OFF_STAT);
    wire stat_wr = bus_wr && (bus_addr == `SPSI_OFF_STAT);
    wire data_rd = bus_rd && (bus_addr == `SPSI_OFF_DATA);
    wire data_wr = bus_wr && (bus_addr == `SPSI_OFF_DATA);
    wire st1_wr  = bus_wr && (bus_addr == `SPSI_OFF_STAT1);

    // control decode
    wire parity_flag_ie  = ctl0_r[`SPSI_B_PARITY_IRQ_EN];
    wire tbe_ie   = ctl0_r[`SPSI_B_TX_EMPTY_IRQ_EN];
    wire tc_ie    = ctl0_r[`SPSI_B_TX_DONE_IRQ_EN];
    wire rx_not_empty_ie  = ctl0_r[`SPSI_B_RX_FULL_IRQ_EN];
    wire idle_ie  = ctl0_r[`SPSI_B_IDLE_IRQ_EN];
    wire lbd_ie   = ctl1_r[`SPSI_B_LIN_BREAK_IRQ_EN];
    wire err_ie   = ctl2_r[`SPSI_B_ERROR_IRQ_EN];
    wire dma_rx   = ctl2_r[`SPSI_B_DMARX];
    wire cts_en   = ctl2_r[`SPSI_B_FLOW_CTRL_EN];
    wire cts_ie   = ctl2_r[`SPSI_B_FLOW_CHANGE_IRQ_EN];
    wire rt_ie    = ctl3_r[`SPSI_B_RX_TIMEOUT_IRQ_EN];
    wire eb_ie    = ctl3_r[`SPSI_B_BLOCK_END_IRQ_EN];

    assign high_bit_first    = ctl3_r[`SPSI_B_HIGH_BIT_FIRST];
    assign data_level_invert = ctl3_r[`SPSI_B_DATA_LEVEL_INVERT];

    // conventions: both clear gives direct, both set gives inverse
    spsi_conv #(
        .W (DW)
    ) u_tx_conv (
        .msb_first (high_bit_first),
        .invert    (data_level_invert),
        .din       (bus_wdata[DW-1:0]),
        .dout      (tx_mapped)
    );

    spsi_conv #(
        .W (DW)
    ) u_rx_conv (
        .msb_first (high_bit_first),
        .invert    (data_level_invert),
        .din       (rx_line_data),
        .dout      (rx_mapped)
    );

    assign seq_flags = {idle_line_flag, overrun_flag, noise_flag, framing_flag, parity_flag};

    spsi_clrseq #(
        .N (`SPSI_SEQ_N)
    ) u_clrseq (
        .mclk    (mclk),
        .rst     (rst),
        .ce      (ce),
        .stat_rd (stat_rd),
        .data_rd (data_rd),
        .data_wr (data_wr),
        .flags   (seq_flags),
        .clr_rd  (seq_clr_rd),
        .clr_wr  (seq_clr_wr)
    );

    wire clr_idle = seq_clr_rd[4];
    wire clr_ore  = seq_clr_rd[3];
    wire clr_noise_flag = seq_clr_rd[2];
    wire clr_framing_flag = seq_clr_rd[1];
    wire clr_parity_flag = seq_clr_rd[0] | seq_clr_wr[0];

    // a written zero clears (rx_not_empty also on a data read); a one leaves the flag alone
    wire clr_tc   = stat_wr && !bus_wdata[`SPSI_B_TC];
    wire clr_rx_not_empty = (stat_wr && !bus_wdata[`SPSI_B_RX_NOT_EMPTY]) || data_rd;
    wire clr_lin_break_flag = stat_wr && !bus_wdata[`SPSI_B_LIN_BREAK_FLAG];
    wire clr_flow_ctrl_change = stat_wr && !bus_wdata[`SPSI_B_FLOW_CTRL_CHANGE];
    wire clr_rtf  = st1_wr && !bus_wdata[`SPSI_B_RTF];
    wire clr_ebf  = st1_wr && !bus_wdata[`SPSI_B_EBF];

    // first cycle after reset has no prior level to compare against
    wire cts_toggle = cts_en && cts_seen_r && (cts_n != cts_prev_r);
    wire tbe_now    = tx_buffer_empty || tx_load;
    // buffer is kept on overrun; new frame is dropped
    wire rx_accept  = rx_frame_done && (!rx_not_empty || clr_rx_not_empty);

    assign stat_word = {22'h00_0000, flow_ctrl_change, lin_break_flag, tx_buffer_empty,
                        tx_complete, rx_not_empty, idle_line_flag, overrun_flag,
                        noise_flag, framing_flag, parity_flag};
    assign stat1_word = {30'h0000_0000, block_end_flag, rx_timeout_flag};

    // event flags, set wins over any clear in the same cycle
    always @(posedge mclk or posedge rst)
    begin
        if (rst)
        begin
            tx_buffer_empty  <= 1'b1;
            tx_complete      <= 1'b1;
            rx_not_empty     <= 1'b0;
            idle_line_flag   <= 1'b0;
            overrun_flag     <= 1'b0;
            noise_flag       <= 1'b0;
            framing_flag     <= 1'b0;
            parity_flag      <= 1'b0;
            lin_break_flag   <= 1'b0;
            flow_ctrl_change <= 1'b0;
            rx_timeout_flag  <= 1'b0;
            block_end_flag   <= 1'b0;
            cts_prev_r       <= 1'b1;
            cts_seen_r       <= 1'b0;
        end
        else if (ce)
        begin
            tx_buffer_empty  <= tx_load | (tx_buffer_empty & ~data_wr);
            tx_complete      <= (tx_frame_done & tbe_now) | (tx_complete & ~clr_tc);
            rx_not_empty     <= rx_frame_done | (rx_not_empty & ~clr_rx_not_empty);
            idle_line_flag   <= idle_det | (idle_line_flag & ~clr_idle);
            overrun_flag     <= (rx_frame_done & rx_not_empty & ~clr_rx_not_empty)
                                | (overrun_flag & ~clr_ore);
            noise_flag       <= noise_det | (noise_flag & ~clr_noise_flag);
            framing_flag     <= frame_err_det | (framing_flag & ~clr_framing_flag);
            parity_flag      <= parity_err_det | (parity_flag & ~clr_parity_flag);
            lin_break_flag   <= lin_break_det | (lin_break_flag & ~clr_lin_break_flag);
            flow_ctrl_change <= cts_toggle | (flow_ctrl_change & ~clr_flow_ctrl_change);
            rx_timeout_flag  <= rx_timeout_det | (rx_timeout_flag & ~clr_rtf);
            block_end_flag   <= block_end_det | (block_end_flag & ~clr_ebf);
            cts_prev_r       <= cts_n;
            cts_seen_r       <= 1'b1;
        end
    end

    // control registers, data path and read port
    always @(posedge mclk or posedge rst)
    begin
        if (rst)
        begin
            ctl0_r          <= `SPSI_CTL_RESET;
            ctl1_r          <= `SPSI_CTL_RESET;
            ctl2_r          <= `SPSI_CTL_RESET;
            ctl3_r          <= `SPSI_CTL_RESET;
            rx_buf_r        <= {DW{1'b0}};
            tx_line_data    <= {DW{1'b0}};
            tx_line_parity  <= 1'b0;
            tx_data_written <= 1'b0;
            bus_rdata       <= 32'h0000_0000;
        end
        else if (ce)
        begin
            tx_data_written <= data_wr;
            if (bus_wr && bus_addr == `SPSI_OFF_CTL0)
                ctl0_r <= bus_wdata[`SPSI_CTL_W-1:0];
            if (bus_wr && bus_addr == `SPSI_OFF_CTL1)
                ctl1_r <= bus_wdata[`SPSI_CTL_W-1:0];
            if (bus_wr && bus_addr == `SPSI_OFF_CTL2)
                ctl2_r <= bus_wdata[`SPSI_CTL_W-1:0];
            if (bus_wr && bus_addr == `SPSI_OFF_CTL3)
                ctl3_r <= bus_wdata[`SPSI_CTL_W-1:0];
            if (data_wr)
            begin
                tx_line_data   <= tx_mapped;
                // even parity on logical bits, carried at line level
                tx_line_parity <= (^bus_wdata[DW-1:0]) ^ data_level_invert;
            end
            if (rx_accept)
                rx_buf_r <= rx_mapped;
            bus_rdata <= 32'h0000_0000;
            if (bus_rd)
            begin
                case (bus_addr)
                    `SPSI_OFF_STAT:  bus_rdata <= stat_word;
                    `SPSI_OFF_DATA:  bus_rdata <= {{(32-DW){1'b0}}, rx_buf_r};
                    `SPSI_OFF_CTL0:  bus_rdata <= {16'h0000, ctl0_r};
                    `SPSI_OFF_CTL1:  bus_rdata <= {16'h0000, ctl1_r};
                    `SPSI_OFF_CTL2:  bus_rdata <= {16'h0000, ctl2_r};
                    `SPSI_OFF_CTL3:  bus_rdata <= {16'h0000, ctl3_r};
                    `SPSI_OFF_STAT1: bus_rdata <= stat1_word;
                    default:         bus_rdata <= 32'h0000_0000;
                endcase
            end
        end
    end

    // one request line from every enabled source; noise and framing errors also need dma_rx set, overrun too unless rx_not_empty_ie is set
    assign irq = (tx_buffer_empty & tbe_ie)
               | (tx_complete & tc_ie)
               | ((rx_not_empty | overrun_flag) & rx_not_empty_ie)
               | (idle_line_flag & idle_ie)
               | (parity_flag & parity_flag_ie)
               | (lin_break_flag & lbd_ie)
               | (flow_ctrl_change & cts_ie)
               | (rx_timeout_flag & rt_ie)
               | (block_end_flag & eb_ie)
               | (dma_rx & err_ie & (noise_flag | overrun_flag | framing_flag));
endmodule // spsi_top

// *** src/spsi_defs.vh ***
`ifndef SPSI_DEFS_VH
`define SPSI_DEFS_VH

// register offsets, byte addresses
`define SPSI_AW            8
`define SPSI_OFF_STAT      8'h00
`define SPSI_OFF_DATA      8'h04
`define SPSI_OFF_CTL0      8'h0C
`define SPSI_OFF_CTL1      8'h10
`define SPSI_OFF_CTL2      8'h14
`define SPSI_OFF_CTL3      8'h18
`define SPSI_OFF_STAT1     8'h1C

// line_status_flags
`define SPSI_STAT_RESET    32'h0000_00C0
`define SPSI_B_PARITY_FLAG        0
`define SPSI_B_FRAMING_FLAG        1
`define SPSI_B_NOISE_FLAG        2
`define SPSI_B_ORE         3
`define SPSI_B_IDLE        4
`define SPSI_B_RX_NOT_EMPTY        5
`define SPSI_B_TC          6
`define SPSI_B_TBE         7
`define SPSI_B_LIN_BREAK_FLAG        8
`define SPSI_B_FLOW_CTRL_CHANGE        9

// second status word
`define SPSI_B_RTF         0
`define SPSI_B_EBF         1

// control fields
`define SPSI_B_PARITY_IRQ_EN      8
`define SPSI_B_TX_EMPTY_IRQ_EN       7
`define SPSI_B_TX_DONE_IRQ_EN        6
`define SPSI_B_RX_FULL_IRQ_EN      5
`define SPSI_B_IDLE_IRQ_EN      4
`define SPSI_B_LIN_BREAK_IRQ_EN       6
`define SPSI_B_ERROR_IRQ_EN       0
`define SPSI_B_DMARX       6
`define SPSI_B_FLOW_CTRL_EN       9
`define SPSI_B_FLOW_CHANGE_IRQ_EN       10
`define SPSI_B_RX_TIMEOUT_IRQ_EN        4
`define SPSI_B_BLOCK_END_IRQ_EN        5
`define SPSI_B_DATA_LEVEL_INVERT        10
`define SPSI_B_HIGH_BIT_FIRST        11

`define SPSI_CTL_W         16
`define SPSI_CTL_RESET     16'h0000
`define SPSI_SEQ_N         5

`endif

// *** src/spsi_conv.v ***
// bit order and level mapping between logical data and line bits;
// reversal and inversion commute, so one module serves both directions
module spsi_conv #(
    parameter W = 8
) (
    input  wire         msb_first,
    input  wire         invert,
    input  wire [W-1:0] din,
    output wire [W-1:0] dout
);
    genvar i;
    generate
        for (i = 0; i < W; i = i + 1)
        begin : g_bit
            assign dout[i] = (msb_first ? din[W-1-i] : din[i]) ^ invert;
        end
    endgenerate
endmodule // spsi_conv

// *** src/spsi_clrseq.v ***
// status read then data access clears only what the status read showed
module spsi_clrseq #(
    parameter N = 5
) (
    input  wire         mclk,
    input  wire         rst,
    input  wire         ce,
    input  wire         stat_rd,
    input  wire         data_rd,
    input  wire         data_wr,
    input  wire [N-1:0] flags,
    output wire [N-1:0] clr_rd,
    output wire [N-1:0] clr_wr
);
    reg         armed_r;
    reg [N-1:0] snap_r;

    // snapshot keeps later-set flags out of the clear
    assign clr_rd = (armed_r && data_rd) ? snap_r : {N{1'b0}};
    assign clr_wr = (armed_r && data_wr) ? snap_r : {N{1'b0}};

    always @(posedge mclk or posedge rst)
    begin
        if (rst)
        begin
            armed_r <= 1'b0;
            snap_r  <= {N{1'b0}};
        end
        else if (ce)
        begin
            if (stat_rd)
            begin
                armed_r <= 1'b1;
                snap_r  <= flags;
            end
            else if (data_rd || data_wr)
            begin
                armed_r <= 1'b0;
            end
        end
    end
endmodule // spsi_clrseq

// *** verification/spsi_props.sv ***
module spsi_props (
    input wire        mclk,
    input wire        rst,
    input wire [7:0]  bus_addr,
    input wire [31:0] bus_wdata,
    input wire        bus_wr,
    input wire        bus_rd,
    input wire [31:0] bus_rdata,
    input wire        tx_load,
    input wire        rx_frame_done,
    input wire        idle_det,
    input wire        noise_det,
    input wire        frame_err_det,
    input wire        parity_err_det,
    input wire        lin_break_det,
    input wire [7:0]  tx_line_data,
    input wire        tx_line_parity,
    input wire        high_bit_first,
    input wire        data_level_invert,
    input wire        irq
);
    timeunit 1ns;
    timeprecision 1ps;
    reg        quiet_r;
    wire [7:0] rev_wdata = {<<{bus_wdata[7:0]}};
    default clocking cb @(posedge mclk); endclocking
    default disable iff (rst);
    // status is only predictable until the first write or receive event
    always @(posedge mclk or posedge rst)
        if (rst)
            quiet_r <= 1'b1;
        else if (bus_wr | rx_frame_done | idle_det | noise_det | frame_err_det
                 | parity_err_det | lin_break_det)
            quiet_r <= 1'b0;
    sequence s_stat_rd; bus_rd && bus_addr == 8'h00; endsequence
    sequence s_data_rd; bus_rd && bus_addr == 8'h04; endsequence
    sequence s_data_wr; bus_wr && bus_addr == 8'h04; endsequence
    sequence s_rx_alone; rx_frame_done && !bus_wr && !bus_rd; endsequence
    a_reset_status: assert property (quiet_r ##0 s_stat_rd |=> bus_rdata == 32'h0000_00C0)
        else $error("status reset value wrong");
    a_reset_irq: assert property (quiet_r |-> !irq)
        else $error("irq raised with nothing enabled");
    a_direct_conv: assert property (s_data_wr ##0 (!high_bit_first && !data_level_invert) |=>
        tx_line_data == $past(bus_wdata[7:0]) && tx_line_parity == ^$past(bus_wdata[7:0]))
        else $error("direct convention mapping wrong");
    a_inverse_conv: assert property (s_data_wr ##0 (high_bit_first && data_level_invert) |=>
        tx_line_data == ~$past(rev_wdata) && tx_line_parity == !(^$past(bus_wdata[7:0])))
        else $error("inverse convention mapping wrong");
    a_tbe_clear: assert property ((s_data_wr ##0 !tx_load) ##1 !tx_load ##1 s_stat_rd |=>
        !bus_rdata[7]) else $error("tx empty not cleared by data write");
    a_lin_set: assert property (lin_break_det ##1 !bus_wr ##1 s_stat_rd |=> bus_rdata[8])
        else $error("lin break flag not set");
    a_rxne_set: assert property (rx_frame_done ##1 !(bus_wr || bus_rd) ##1 s_stat_rd |=>
        bus_rdata[5]) else $error("rx not empty not set");
    a_overrun_set: assert property (s_rx_alone ##1 !(bus_wr || bus_rd) ##1 s_rx_alone
        ##1 !bus_rd ##1 s_stat_rd |=> bus_rdata[3]) else $error("overrun flag not set");
    a_seq_clear: assert property ((!idle_det throughout (s_stat_rd ##1 !(bus_wr || bus_rd)
        ##1 s_data_rd ##1 1'b1)) ##1 s_stat_rd |=> !bus_rdata[4])
        else $error("idle flag not cleared by read sequence");
endmodule // spsi_props

bind spsi_top spsi_props i_spsi_props (.mclk(mclk), .rst(rst), .bus_addr(bus_addr),
    .bus_wdata(bus_wdata), .bus_wr(bus_wr), .bus_rd(bus_rd), .bus_rdata(bus_rdata),
    .tx_load(tx_load), .rx_frame_done(rx_frame_done), .idle_det(idle_det),
    .noise_det(noise_det), .frame_err_det(frame_err_det), .parity_err_det(parity_err_det),
    .lin_break_det(lin_break_det), .tx_line_data(tx_line_data),
    .tx_line_parity(tx_line_parity), .high_bit_first(high_bit_first),
    .data_level_invert(data_level_invert), .irq(irq));

// *** verification/spsi_line_partner.sv ***
module spsi_line_partner (
    input  wire       mclk,
    input  wire       rst,
    input  wire       tx_data_written,
    input  wire       slow,
    output reg        tx_load = 1'b0,
    output reg        tx_frame_done = 1'b0,
    output reg        rx_frame_done = 1'b0,
    output reg  [7:0] rx_line_data = 8'h00,
    output reg  [6:0] det = 7'h00,
    output reg        cts_n = 1'b1
);
    timeunit 1ns;
    timeprecision 1ps;
    reg [3:0] cnt_r;
    // slow mode stands for a long frame on the line, fast for a short one
    always @(posedge mclk or posedge rst)
        if (rst)
        begin
            cnt_r         <= 4'h0;
            tx_load       <= 1'b0;
            tx_frame_done <= 1'b0;
        end
        else
        begin
            cnt_r         <= tx_data_written ? (slow ? 4'h9 : 4'h3) : cnt_r - {3'h0, cnt_r != 4'h0};
            tx_load       <= cnt_r == 4'h2;
            tx_frame_done <= cnt_r == 4'h1;
        end
    task automatic frame(input logic [7:0] d);
        @(posedge mclk);
        rx_line_data  <= d;
        rx_frame_done <= 1'b1;
        @(posedge mclk);
        rx_frame_done <= 1'b0;
        // no longer valid: show the inverse, never the held value
        rx_line_data  <= ~d;
    endtask
    // k: 0 idle, 1 noise, 2 framing, 3 parity, 4 lin, 5 timeout, 6 block end,
    // 7 frame, 8 cts toggle, other: nothing
    task automatic pulse(input int k);
        if (k == 7)
            frame(8'h3C);
        else
        begin
            @(posedge mclk);
            if (k < 7)
                det[k] <= 1'b1;
            if (k == 8)
                cts_n <= ~cts_n;
            @(posedge mclk);
            det <= 7'h00;
        end
    endtask
endmodule // spsi_line_partner

// *** verification/testbench.sv ***
module testbench;
    timeunit 1ns;
    timeprecision 1ps;
    logic        mclk = 1'b0, rst = 1'b1, ce = 1'b1, bus_wr = 1'b0, bus_rd = 1'b0, slow = 1'b0;
    logic [7:0]  bus_addr = 8'h00;
    logic [31:0] bus_wdata = 32'h0, rdv, seed = 32'd67117;
    logic [1:0]  m;
    logic [8:0]  e;
    wire  [31:0] bus_rdata;
    wire  [7:0]  rx_line_data, tx_line_data;
    wire  [6:0]  det;
    wire         tx_load, tx_frame_done, rx_frame_done, cts_n, tx_line_parity;
    wire         tx_data_written, high_bit_first, data_level_invert, irq;
    int          fail_count = 0, compares = 0;
    logic [7:0]  ea [10] = '{8'h0C, 8'h0C, 8'h10, 8'h18, 8'h18, 8'h0C, 8'h14, 8'h14, 8'h0C, 8'h0C};
    logic [15:0] em [10] = '{16'h0010, 16'h0100, 16'h0040, 16'h0010, 16'h0020, 16'h0020,
                             16'h0600, 16'h0041, 16'h0080, 16'h0040};
    int          ek [10] = '{0, 3, 4, 5, 6, 7, 8, 1, 9, 9};
    always #12.5 mclk = ~mclk;
    spsi_top i_spsi_top (.mclk(mclk), .rst(rst), .ce(ce), .bus_addr(bus_addr),
        .bus_wdata(bus_wdata), .bus_wr(bus_wr), .bus_rd(bus_rd), .bus_rdata(bus_rdata),
        .tx_load(tx_load), .tx_frame_done(tx_frame_done), .rx_frame_done(rx_frame_done),
        .rx_line_data(rx_line_data), .idle_det(det[0]), .noise_det(det[1]),
        .frame_err_det(det[2]), .parity_err_det(det[3]), .lin_break_det(det[4]),
        .rx_timeout_det(det[5]), .block_end_det(det[6]), .cts_n(cts_n),
        .tx_line_data(tx_line_data), .tx_line_parity(tx_line_parity),
        .tx_data_written(tx_data_written), .high_bit_first(high_bit_first),
        .data_level_invert(data_level_invert), .irq(irq));
    spsi_line_partner i_spsi_line_partner (.mclk(mclk), .rst(rst),
        .tx_data_written(tx_data_written), .slow(slow), .tx_load(tx_load),
        .tx_frame_done(tx_frame_done), .rx_frame_done(rx_frame_done),
        .rx_line_data(rx_line_data), .det(det), .cts_n(cts_n));
    function automatic logic [31:0] lfsr(input logic [31:0] x);
        return x[0] ? (x >> 1) ^ 32'h8020_0003 : x >> 1;
    endfunction
    // {parity, line bits} for mode {msb first, invert}
    function automatic logic [8:0] line_of(input logic [7:0] v, input logic [1:0] md);
        logic [7:0] r;
        for (int i = 0; i < 8; i++)
            r[i] = md[1] ? v[7 - i] : v[i];
        return {^v ^ md[0], r ^ {8{md[0]}}};
    endfunction
    task automatic chk(input string name, input logic [31:0] seen, input logic [31:0] exp);
        compares++;
        if (seen !== exp)
        begin
            $display("mismatch %s expected %h seen %h", name, exp, seen);
            fail_count++;
        end
    endtask
    task automatic wr(input logic [7:0] a, input logic [31:0] d);
        @(posedge mclk);
        bus_wr <= 1'b1;
        bus_addr <= a;
        bus_wdata <= d;
        @(posedge mclk);
        bus_wr <= 1'b0;
        #1;
    endtask
    task automatic rd(input logic [7:0] a);
        @(posedge mclk);
        bus_rd <= 1'b1;
        bus_addr <= a;
        @(posedge mclk);
        bus_rd <= 1'b0;
        #1 rdv = bus_rdata;
    endtask
    task automatic wrap_up;
        $display("counts: %0d compares, %0d mismatches", compares, fail_count);
        if (fail_count == 0 && compares > 0)
            $display("STATUS OK");
        else
            $display("STATUS NOT OK");
        $finish;
    endtask
    initial
    begin
        #100us;
        fail_count++;
        wrap_up;
    end
    initial
    begin
        repeat (8) @(posedge mclk);
        rst <= 1'b0;
        rd(8'h00);
        chk("status after reset", rdv, 32'h0000_00C0);
        chk("irq after reset", {31'h0, irq}, 32'h0);
        rd(8'h40);
        chk("unmapped read", rdv, 32'h0);
        $display("test reset done");
        for (int n = 0; n < 8; n++)
        begin
            seed = lfsr(seed);
            m = n[0] ? 2'b11 : 2'b00;
            slow <= seed[9];
            wr(8'h18, {20'h0, m, 10'h0});
            wr(8'h00, 32'h0);
            wr(8'h04, {24'h0, seed[7:0]});
            e = line_of(seed[7:0], m);
            chk("tx line data", {24'h0, tx_line_data}, {24'h0, e[7:0]});
            chk("tx parity", {31'h0, tx_line_parity}, {31'h0, e[8]});
            rd(8'h00);
            chk("tx flags busy", {30'h0, rdv[7:6]}, 32'h0);
            repeat (14) @(posedge mclk);
            rd(8'h00);
            chk("tx flags idle", {30'h0, rdv[7:6]}, 32'h3);
        end
        wr(8'h18, 32'h0);
        $display("test convention done");
        for (int n = 0; n < 10; n++)
        begin
            wr(ea[n], {16'h0, em[n]});
            chk("irq before event", {31'h0, irq}, {31'h0, ek[n] == 9});
            i_spsi_line_partner.pulse(ek[n]);
            #1 chk("irq on event", {31'h0, irq}, 32'h1);
            wr(ea[n], 32'h0);
            chk("irq disabled", {31'h0, irq}, 32'h0);
        end
        rd(8'h1C);
        chk("status1 set", rdv, 32'h3);
        wr(8'h1C, 32'h0);
        rd(8'h1C);
        chk("status1 cleared", rdv, 32'h0);
        $display("test irq done");
        rd(8'h04);
        chk("rx data", rdv, 32'h3C);
        rd(8'h00);
        chk("rx empty after read", {31'h0, rdv[5]}, 32'h0);
        i_spsi_line_partner.frame(8'hA5);
        i_spsi_line_partner.frame(8'h5A);
        rd(8'h00);
        chk("overrun", {30'h0, rdv[5], rdv[3]}, 32'h3);
        wr(8'h00, 32'h0);
        wr(8'h0C, 32'h0020);
        chk("overrun irq", {31'h0, irq}, 32'h1);
        rd(8'h00);
        rd(8'h04);
        chk("old rx data kept", rdv, 32'hA5);
        chk("overrun irq cleared", {31'h0, irq}, 32'h0);
        rd(8'h00);
        chk("status after sequence", rdv, 32'h0000_0080);
        wr(8'h0C, 32'h0);
        $display("test overrun done");
        i_spsi_line_partner.pulse(2);
        i_spsi_line_partner.pulse(8);
        i_spsi_line_partner.pulse(4);
        rd(8'h00);
        chk("framing lin no cts", rdv, 32'h0000_0182);
        wr(8'h00, 32'h0000_0080);
        i_spsi_line_partner.pulse(0);
        rd(8'h04);
        rd(8'h00);
        chk("late idle survives", rdv, 32'h0000_0090);
        i_spsi_line_partner.pulse(3);
        rd(8'h00);
        wr(8'h04, 32'h0);
        rd(8'h00);
        chk("parity cleared by write", rdv, 32'h0000_0010);
        $display("test sequence done");
        // mid-run reset must bring every flag back to its power-on value
        @(posedge mclk);
        rst <= 1'b1;
        repeat (8) @(posedge mclk);
        rst <= 1'b0;
        rd(8'h00);
        chk("status after second reset", rdv, 32'h0000_00C0);
        // a write while the clock enable is low is lost
        ce <= 1'b0;
        wr(8'h0C, 32'h0000_0080);
        ce <= 1'b1;
        chk("irq after frozen write", {31'h0, irq}, 32'h0);
        rd(8'h0C);
        chk("ctl0 after frozen write", rdv, 32'h0);
        wr(8'h0C, 32'h0000_0080);
        chk("irq after live write", {31'h0, irq}, 32'h1);
        wr(8'h0C, 32'h0);
        $display("test reset and enable done");
        wrap_up;
    end
endmodule // testbench
